// *** hw/pipelined_burst_sram_port.sv ***
// pipelined burst sram port: write fifo and device logic
`timescale 1ns/1ns
`default_nettype none
`include "sram_port_consts.svh"

// ****************************************
// write fifo
// ****************************************
module write_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int PW = $clog2(DEPTH);
    generate
        if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
            $error("fifo depth must be a power of two of at least two");
        end
    endgenerate
    typedef struct packed {
        logic [PW-1:0] rd;
        logic [PW-1:0] wr;
        logic [PW:0]   cnt;
    } fifo_state_t;
    fifo_state_t     f_reg;
    fifo_state_t     f_next;
    logic [WIDTH-1:0] store [DEPTH];
    logic            push;
    logic            pop;
    assign inReady  = f_reg.cnt != (PW+1)'(DEPTH);
    assign outValid = f_reg.cnt != '0;
    assign outData  = store[f_reg.rd];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;
    always_comb begin
        f_next = f_reg;
        if (push) begin
            f_next.wr = f_reg.wr + PW'(1);
        end
        if (pop) begin
            f_next.rd = f_reg.rd + PW'(1);
        end
        unique case ({push, pop})
            2'h2: f_next.cnt = f_reg.cnt + (PW+1)'(1);
            2'h1: f_next.cnt = f_reg.cnt - (PW+1)'(1);
            default: f_next.cnt = f_reg.cnt;
        endcase
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            f_reg <= '0;
        end else begin
            f_reg <= f_next;
        end
    end
    // storage needs no reset; only valid slots are ever read out
    always_ff @(posedge clk) begin
        if (push) begin
            store[f_reg.wr] <= inData;
        end
    end
endmodule
// ****************************************
// device logic
// ****************************************
module pipelined_burst_sram_port #(
    parameter int ADDR_W     = `MEM_ADDR_W,
    parameter int FIFO_DEPTH = `WFIFO_DEPTH
) (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic [ADDR_W-1:0]    addrIn,
    input  wire sram_port_pkg::word_t dqIn,
    output sram_port_pkg::word_t      dqOut,
    output logic                      dqOeN,
    input  wire logic                 master_select_n,
    input  wire logic                 select_hi,
    input  wire logic                 select_lo_n,
    input  wire logic                 proc_addr_strobe_n,
    input  wire logic                 ctrl_addr_strobe_n,
    input  wire logic                 burst_step_n,
    input  wire logic                 global_write_n,
    input  wire logic                 byte_write_gate_n,
    input  wire sram_port_pkg::lane_t byte_lane_write_n,
    input  wire logic                 outputEnableN,
    input  wire logic                 burst_order_select_n,
    input  wire logic                 sleep_request
);
    import sram_port_pkg::*;
    localparam int FW = ADDR_W + `WORD_W + `LANE_COUNT;
    generate
        if (ADDR_W < `BURST_W + 1) begin : g_bad_addr
            $error("address must be wider than the burst counter");
        end
    endgenerate
    typedef struct packed {
        logic              oeMeta;
        logic              oeSync;
        logic              zzMeta;
        logic              zzSync;
        logic              lboMeta;
        logic              lboSync;
        logic [ADDR_W-1:0] base;
        burst_t            step;
        op_t               op;
        logic              rdPend;
        word_t             dq;
        logic              dqOeN;
    } state_t;
    state_t            s_reg;
    state_t            s_next;
    word_t             mem [2**ADDR_W];
    logic              sleep;
    logic              procStrobe;
    logic              ctrlStrobe;
    logic              strobe;
    logic              selected;
    lane_t             wrMask;
    order_t            order;
    logic [ADDR_W-1:0] curAddr;
    logic [ADDR_W-1:0] nextAddr;
    word_t             memWord;
    logic              pushValid;
    logic              pushReady;
    logic [FW-1:0]     drainData;
    logic              drainValid;
    logic              drainReady;
    logic [ADDR_W-1:0] drainAddr;
    word_t             drainWord;
    lane_t             drainMask;
    function automatic lane_t laneMask(input logic gw, input logic gate, input lane_t lanes);
        lane_t m;
        m = `MASK_NONE;
        if (!gw) begin
            m = `MASK_ALL;
        end else if (!gate) begin
            m = ~lanes;
        end
        return m;
    endfunction
    function automatic logic [ADDR_W-1:0] burstAddr(input logic [ADDR_W-1:0] b, input burst_t c, input order_t o);
        logic [ADDR_W-1:0] a;
        a = b;
        if (o == ORDER_INTERLEAVED) begin
            a[`BURST_W-1:0] = b[`BURST_W-1:0] ^ c;
        end else begin
            a[`BURST_W-1:0] = b[`BURST_W-1:0] + c;
        end
        return a;
    endfunction
    assign sleep      = s_reg.zzSync;
    // master select gates processor strobe only
    assign procStrobe = ~proc_addr_strobe_n & ~master_select_n;
    assign ctrlStrobe = ~ctrl_addr_strobe_n;
    assign strobe     = procStrobe | ctrlStrobe;
    assign selected   = ~master_select_n & select_hi & ~select_lo_n;
    assign wrMask     = laneMask(global_write_n, byte_write_gate_n, byte_lane_write_n);
    // pull-up modelled by reset value of the synchroniser
    assign order      = s_reg.lboSync ? ORDER_INTERLEAVED : ORDER_LINEAR;
    assign curAddr    = burstAddr(s_reg.base, s_reg.step, order);
    assign nextAddr   = burstAddr(s_next.base, s_next.step, order);
    assign memWord    = mem[curAddr];
    assign pushValid  = s_next.op == OP_WRITE && !sleep;
    assign dqOut      = s_reg.dq;
    assign dqOeN      = s_reg.dqOeN;
    // drain stalls while asleep; pending writes wait for wake
    assign drainReady = ~sleep;
    assign {drainAddr, drainWord, drainMask} = drainData;
    always_comb begin
        s_next = s_reg;
        // two-flop capture of the asynchronous inputs
        s_next.oeMeta  = outputEnableN;
        s_next.oeSync  = s_reg.oeMeta;
        s_next.zzMeta  = sleep_request;
        s_next.zzSync  = s_reg.zzMeta;
        s_next.lboMeta = burst_order_select_n;
        s_next.lboSync = s_reg.lboMeta;
        if (sleep) begin
            s_next.op = OP_IDLE;
        end else if (strobe) begin
            if (selected) begin
                s_next.base = addrIn;
                s_next.step = `BURST_RST;
                // processor strobe ignores step and lanes
                if (!procStrobe && wrMask != `MASK_NONE) begin
                    s_next.op = OP_WRITE;
                end else begin
                    s_next.op = OP_READ;
                end
            end else begin
                s_next.op = OP_IDLE;
            end
        end else if (s_reg.op != OP_IDLE) begin
            // advance; otherwise suspend on same address
            if (!burst_step_n) begin
                s_next.step = s_reg.step + `BURST_STEP;
            end
            s_next.op = (wrMask != `MASK_NONE) ? OP_WRITE : OP_READ;
        end
        s_next.rdPend = s_next.op == OP_READ;
        // array read one cycle after address registered
        if (s_reg.rdPend) begin
            s_next.dq = memWord;
        end
        // drive only for read data with output enable low
        s_next.dqOeN = ~(s_reg.rdPend & ~s_reg.oeSync & ~sleep);
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg         <= '0;
            s_reg.oeMeta  <= `OE_SYNC_RST;
            s_reg.oeSync  <= `OE_SYNC_RST;
            s_reg.zzMeta  <= `ZZ_SYNC_RST;
            s_reg.zzSync  <= `ZZ_SYNC_RST;
            s_reg.lboMeta <= `LBO_SYNC_RST;
            s_reg.lboSync <= `LBO_SYNC_RST;
            s_reg.op      <= OP_IDLE;
            s_reg.dqOeN   <= 1'h1;
        end else begin
            s_reg <= s_next;
        end
    end
    // fifo decouples write capture from the array port
    write_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_wfifo (
        .clk      (clk),
        .rst_b    (rst_b),
        .inData   ({nextAddr, dqIn, wrMask}),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .outData  (drainData),
        .outValid (drainValid),
        .outReady (drainReady)
    );
    // contents kept; array has no reset
    always_ff @(posedge clk) begin
        if (drainValid && drainReady) begin
            for (int i = 0; i < `LANE_COUNT; i++) begin
                if (drainMask[i]) begin
                    mem[drainAddr][i*`LANE_W +: `LANE_W] <= drainWord[i*`LANE_W +: `LANE_W];
                end
            end
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_selStrobe;
        !sleep && strobe && selected;
    endsequence
    sequence s_hold;
        !sleep && !strobe && s_reg.op != OP_IDLE;
    endsequence
    property p_capture;
        s_selStrobe |=> s_reg.base == $past(addrIn) && s_reg.step == `BURST_RST;
    endproperty
    a_capture: assert property (p_capture) else $error("address not captured");

    property p_blocked;
        !sleep && !proc_addr_strobe_n && master_select_n && ctrl_addr_strobe_n |=> $stable(s_reg.base);
    endproperty
    a_blocked: assert property (p_blocked) else $error("blocked strobe loaded address");

    property p_deselect;
        !sleep && strobe && !selected |=> s_reg.op == OP_IDLE ##1 s_reg.dqOeN;
    endproperty
    a_deselect: assert property (p_deselect) else $error("deselect missed");

    property p_advance;
        s_hold ##0 !burst_step_n |=> s_reg.step == $past(s_reg.step) + `BURST_STEP;
    endproperty
    a_advance: assert property (p_advance) else $error("burst did not advance");

    property p_suspend;
        s_hold ##0 burst_step_n |=> $stable(s_reg.step) && $stable(s_reg.base) && s_reg.op != OP_IDLE;
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend moved address");

    property p_procRead;
        s_selStrobe ##0 procStrobe |-> !pushValid ##1 s_reg.op == OP_READ && s_reg.rdPend;
    endproperty
    a_procRead: assert property (p_procRead) else $error("processor strobe not a read");

    property p_write;
        s_selStrobe ##0 !procStrobe && wrMask != `MASK_NONE |-> pushValid ##1 s_reg.op == OP_WRITE;
    endproperty
    a_write: assert property (p_write) else $error("write not started");

    property p_global;
        !global_write_n |-> wrMask == `MASK_ALL;
    endproperty
    a_global: assert property (p_global) else $error("global write lost lanes");

    property p_readPipe;
        s_reg.rdPend |=> s_reg.dq == $past(memWord);
    endproperty
    a_readPipe: assert property (p_readPipe) else $error("read data not one cycle later");

    property p_drive;
        !s_reg.dqOeN |-> $past(s_reg.rdPend) && !$past(s_reg.oeSync) && !$past(sleep);
    endproperty
    a_drive: assert property (p_drive) else $error("data driven outside read");

    property p_interleave;
        s_reg.lboSync |-> curAddr[`BURST_W-1:0] == (s_reg.base[`BURST_W-1:0] ^ s_reg.step);
    endproperty
    a_interleave: assert property (p_interleave) else $error("interleaved order wrong");

    property p_sleep;
        sleep |=> s_reg.dqOeN && s_reg.op == OP_IDLE;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep left outputs active");
endmodule
`default_nettype wire

// *** hw/sram_port_consts.svh ***
// constants of the pipelined burst sram port
`ifndef SRAM_PORT_CONSTS_SVH
`define SRAM_PORT_CONSTS_SVH
`define WORD_W 18
`define LANE_W 9
`define LANE_COUNT 2
`define MEM_ADDR_W 18
`define WFIFO_DEPTH 8
`define BURST_W 2
`define BURST_RST 2'h0
`define BURST_STEP 2'h1
`define MASK_ALL 2'h3
`define MASK_NONE 2'h0
`define OE_SYNC_RST 1'h1
`define ZZ_SYNC_RST 1'h0
`define LBO_SYNC_RST 1'h1
`endif

// *** hw/sram_port_pkg.sv ***
// types shared by the pipelined burst sram port
`include "sram_port_consts.svh"
package sram_port_pkg;
    typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} op_t;
    typedef enum logic {ORDER_LINEAR, ORDER_INTERLEAVED} order_t;
    typedef logic [`WORD_W-1:0]     word_t;
    typedef logic [`LANE_COUNT-1:0] lane_t;
    typedef logic [`BURST_W-1:0]    burst_t;
endpackage

// *** sim/bus_master_model.sv ***
// bus master model driving the synchronous and asynchronous inputs of the sram port
`timescale 1ns/1ns
`default_nettype none

// ********
// bus master
// ********
module bus_master_model #(
    parameter int AW = 6
) (
    input  wire logic            clk,
    output logic [AW-1:0]        addrIn,
    output sram_port_pkg::word_t dqIn,
    output logic                 master_select_n,
    output logic                 select_hi,
    output logic                 select_lo_n,
    output logic                 proc_addr_strobe_n,
    output logic                 ctrl_addr_strobe_n,
    output logic                 burst_step_n,
    output logic                 global_write_n,
    output logic                 byte_write_gate_n,
    output sram_port_pkg::lane_t byte_lane_write_n,
    output logic                 outputEnableN,
    output logic                 burst_order_select_n,
    output logic                 sleep_request
);
    import sram_port_pkg::*;
    logic oeReq = 1'h0;
    initial begin
        addrIn = '0;
        dqIn = 18'h15a5a;
        {master_select_n, select_hi, select_lo_n} = 3'h2;
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = 3'h7;
        {global_write_n, byte_write_gate_n, byte_lane_write_n} = 4'hf;
        {outputEnableN, burst_order_select_n, sleep_request} = 3'h2;
    end
    // one bus cycle; released data lines toggle so stale data never reads as valid
    task automatic beat(input logic p, input logic c, input logic [2:0] sel, input logic [AW-1:0] a,
                        input logic s, input logic [3:0] w, input word_t d);
        @(posedge clk);
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} <= {p, c, s};
        {master_select_n, select_hi, select_lo_n} <= sel;
        {global_write_n, byte_write_gate_n, byte_lane_write_n} <= w;
        addrIn <= a;
        dqIn <= (w == 4'hf) ? ~dqIn : d;
        outputEnableN <= (w != 4'hf && p) ? 1'h1 : oeReq;
    endtask
    // slow pins; strobes idle on this edge only, callers may strobe on the next edge while sleep is still being synchronised
    task automatic setAsync(input logic oe, input logic ord, input logic slp);
        @(posedge clk);
        oeReq = oe;
        outputEnableN <= oe;
        burst_order_select_n <= ord;
        sleep_request <= slp;
        {proc_addr_strobe_n, ctrl_addr_strobe_n} <= 2'h3;
    endtask
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench of the pipelined burst sram port
`timescale 1ns/1ns
`default_nettype none
module tb;
    import sram_port_pkg::*;
    localparam int AW = 6;
    localparam logic [2:0] SEL = 3'h2;
    typedef struct packed {logic [AW-1:0] a; logic [3:0] w; word_t q;} row_t;
    logic          clk = 1'h0;
    logic          rst_b = 1'h0;
    logic [AW-1:0] addrIn;
    word_t         dqIn, dqOut;
    logic          dqOeN, mSelN, selHi, selLoN, procN, ctrlN, stepN, gwN, gateN, oeN, ordN, sleep;
    lane_t         lanesN;
    int            failures = 0;
    int            tests_run = 0;
    word_t         shadow [64];
    // base word 0f0f0, row data 2aaaa; q is the word read back
    row_t rows [6] = '{'{6'h04, 4'h7, 18'h2aaaa}, '{6'h05, 4'ha, 18'h0f0aa}, '{6'h06, 4'h9, 18'h2aaf0},
                       '{6'h07, 4'h8, 18'h2aaaa}, '{6'h08, 4'hb, 18'h0f0f0}, '{6'h09, 4'hc, 18'h0f0f0}};
    // {proc, ctrl, selects} of strobes that must deselect
    logic [4:0] desel [5] = '{5'h16, 5'h10, 5'h13, 5'h08, 5'h0b};

    bus_master_model #(.AW(AW)) bm (.clk(clk), .addrIn(addrIn), .dqIn(dqIn), .master_select_n(mSelN),
        .select_hi(selHi), .select_lo_n(selLoN), .proc_addr_strobe_n(procN), .ctrl_addr_strobe_n(ctrlN),
        .burst_step_n(stepN), .global_write_n(gwN), .byte_write_gate_n(gateN), .byte_lane_write_n(lanesN),
        .outputEnableN(oeN), .burst_order_select_n(ordN), .sleep_request(sleep));
    pipelined_burst_sram_port #(.ADDR_W(AW)) uut (.clk(clk), .rst_b(rst_b), .addrIn(addrIn), .dqIn(dqIn),
        .dqOut(dqOut), .dqOeN(dqOeN), .master_select_n(mSelN), .select_hi(selHi), .select_lo_n(selLoN),
        .proc_addr_strobe_n(procN), .ctrl_addr_strobe_n(ctrlN), .burst_step_n(stepN), .global_write_n(gwN),
        .byte_write_gate_n(gateN), .byte_lane_write_n(lanesN), .outputEnableN(oeN),
        .burst_order_select_n(ordN), .sleep_request(sleep));

    initial begin
        forever #5 clk = ~clk;
    end

    // ********
    // helpers
    // ********
    task automatic chk(input string n, input word_t e, input word_t g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) bm.beat(1'h1, 1'h1, SEL, '0, 1'h1, 4'hf, '0);
    endtask
    task automatic one(input logic [AW-1:0] a, input logic [3:0] w, input word_t d);
        bm.beat(1'h1, 1'h0, SEL, a, 1'h1, w, d);
    endtask
    // strobe then data one edge later; probe reads back only the drive enable
    task automatic probe(input logic p, input logic c, input logic [2:0] s, input logic e);
        bm.beat(p, c, s, 6'h3c, 1'h1, 4'hf, '0);
        idle(2);
        #1;
        chk1("dqOeN", e, dqOeN);
    endtask
    // four-beat burst; stp[k] is the step input of beat k for k 1 to 3, continuing beats with master select and select_hi off
    task automatic burst(input logic [AW-1:0] a, input logic [3:0] stp, input logic wr, input logic lin);
        logic [AW-1:0] ad [4];
        logic [1:0]    n;
        word_t         d;
        n = 2'h0;
        for (int k = 0; k < 4; k++) begin
            if (k > 0 && !stp[k]) n = n + 2'h1;
            ad[k] = {a[AW-1:2], lin ? a[1:0] + n : a[1:0] ^ n};
        end
        for (int k = 0; k < 8; k++) begin
            if (k < 2 || k > 5) begin
                idle(1);
            end else begin
                d = 18'h20000 | word_t'(ad[k-2]) | word_t'(k << 8);
                if (wr) shadow[ad[k-2]] = d;
                if (k == 2) bm.beat(wr, ~wr, SEL, a, 1'h1, 4'h0, d);
                else bm.beat(1'h1, 1'h1, 3'h4, '0, stp[k-2], {~wr, 3'h7}, d);
            end
            #1;
            if (!wr && k > 3) begin
                chk("dqOut", shadow[ad[k-4]], dqOut);
                chk1("dqOeN", 1'h0, dqOeN);
            end
        end
    endtask
    task automatic wrap_up();
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ********
    // scenarios
    // ********
    initial begin
        repeat (3) @(posedge clk);
        #1;
        chk1("dqOeN", 1'h1, dqOeN);
        chk("dqOut", '0, dqOut);
        repeat (5) @(posedge clk);
        rst_b <= 1'h1;
        idle(3);
        foreach (rows[i]) begin
            one(rows[i].a, 4'h0, 18'h0f0f0);
            one(rows[i].a, rows[i].w, 18'h2aaaa);
            shadow[rows[i].a] = rows[i].q;
            burst(rows[i].a, 4'hf, 1'h0, 1'h0);
        end
        bm.setAsync(1'h0, 1'h0, 1'h0);
        burst(6'h3e, 4'h0, 1'h1, 1'h1);
        burst(6'h3f, 4'h4, 1'h0, 1'h1);
        bm.setAsync(1'h0, 1'h1, 1'h0);
        burst(6'h3d, 4'h4, 1'h1, 1'h0);
        burst(6'h3e, 4'h0, 1'h0, 1'h0);
        foreach (desel[i]) begin
            probe(1'h0, 1'h1, SEL, 1'h0);
            probe(desel[i][4], desel[i][3], desel[i][2:0], 1'h1);
        end
        probe(1'h0, 1'h1, 3'h6, 1'h1);
        bm.setAsync(1'h1, 1'h1, 1'h0);
        probe(1'h0, 1'h1, SEL, 1'h1);
        bm.setAsync(1'h0, 1'h1, 1'h0);
        probe(1'h0, 1'h1, SEL, 1'h0);
        bm.setAsync(1'h0, 1'h1, 1'h1);
        probe(1'h0, 1'h1, SEL, 1'h1);
        one(6'h3e, 4'h0, 18'h3ffff);
        bm.setAsync(1'h0, 1'h1, 1'h0);
        burst(6'h3e, 4'h0, 1'h0, 1'h0);
        wrap_up();
    end

    initial begin
        #100000;
        failures++;
        wrap_up();
    end
endmodule
`default_nettype wire
